//--- bench/pmsc_host.sv
// Host model: presents trigger levels to the block, promptly or late
`default_nettype none
module pmsc_host (
  input  wire logic                 i_mclk,
  input  wire pmsc_pkg::pmsc_trig_t i_cmd,
  input  wire logic                 i_slow,
  output wire pmsc_pkg::pmsc_trig_t o_trig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]           wait_q = 2'h0;
  pmsc_pkg::pmsc_trig_t trig_q = '0;
  // Host copies the commanded levels on the falling edge; in slow mode a change waits two extra cycles
  always @(negedge i_mclk) begin
    if (i_cmd == trig_q) wait_q <= 2'h0;
    else if (!i_slow || wait_q == 2'h2) trig_q <= i_cmd;
    else wait_q <= wait_q + 2'h1;
  end
  assign o_trig = trig_q;
endmodule : pmsc_host
`default_nettype wire

//--- bench/pmsc_monitor.sv
// Checker: state, rail and setting relations at the top module ports
`default_nettype none
module pmsc_monitor #(
  parameter int EXIT_CYCLES = 4
) (
  input wire logic                  i_mclk,
  input wire logic                  i_rstn,
  input wire pmsc_pkg::pmsc_trig_t  i_trig,
  input wire pmsc_pkg::pmsc_rails_t o_rails,
  input wire logic                  o_external_drive_enable,
  input wire logic                  o_residual_check_enable,
  input wire logic                  o_first_startup_done,
  input wire logic                  o_analog_supply_monitor_mask,
  input wire logic                  o_to_fault_recovery,
  input wire logic                  o_link_crc_check_enable,
  input wire logic [1:0]            o_link_retry_limit,
  input wire logic                  o_link_watchdog_enable,
  input wire logic                  o_link_watchdog_auto_boot,
  input wire logic                  o_link_logical_secondary,
  input wire logic [2:0]            o_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // Standby dwell counter, saturating so a long stay cannot wrap
  logic [7:0] stby_q;
  logic [7:0] stby_d;
  always_comb begin
    stby_d = 8'h00;
    if (o_state == pmsc_pkg::PMSC_STANDBY) begin
      stby_d = (stby_q == 8'hff) ? stby_q : stby_q + 8'h01;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) stby_q <= 8'h00;
    else stby_q <= stby_d;
  end
  // ==========================================================
  // Rail and drive relations per state, then setting and transition checks
  chk_standby_dark: assert property (o_state == pmsc_pkg::PMSC_STANDBY |->
    o_rails == '0 && !o_external_drive_enable) else $error("standby not dark");
  chk_active_full: assert property (o_state == pmsc_pkg::PMSC_ACTIVE |->
    o_rails == 12'hfff && o_external_drive_enable) else $error("active rails");
  chk_mcu_only: assert property (o_state == pmsc_pkg::PMSC_MCU |->
    o_rails.mcu == 4'hf && o_rails.soc == 8'h00) else $error("mcu only rails");
  chk_retain_ddr: assert property (o_state == pmsc_pkg::PMSC_RETAIN |->
    o_rails == 12'h007 && !o_external_drive_enable) else $error("retention rails");
  chk_link_fixed: assert property (o_link_crc_check_enable &&
    o_link_retry_limit == 2'h3 && o_link_watchdog_enable && o_link_watchdog_auto_boot
    && o_link_logical_secondary) else $error("link setting wrong");
  chk_entry_init: assert property (o_state == pmsc_pkg::PMSC_PREACT |->
    !o_residual_check_enable && o_first_startup_done && !o_analog_supply_monitor_mask)
    else $error("entry init missing");
  chk_on_needed: assert property (o_state == pmsc_pkg::PMSC_ACTIVE &&
    $past(o_state) == pmsc_pkg::PMSC_PREACT |-> $past(i_trig.on_req, 3))
    else $error("active without on request");
  chk_soc_err_exit: assert property ($past(o_state) == pmsc_pkg::PMSC_SOC_ERR &&
    o_state != pmsc_pkg::PMSC_SOC_ERR |-> o_state == pmsc_pkg::PMSC_MCU)
    else $error("bad exit from soc error");
  chk_exit_standby: assert property ($rose(o_to_fault_recovery) |->
    $past(o_state) == pmsc_pkg::PMSC_STANDBY && stby_q >= EXIT_CYCLES)
    else $error("recovery without exit sequence");
endmodule : pmsc_monitor
`default_nettype wire

//--- bench/tb_top.sv
// Testbench top: drives the mission state block and judges its ports
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EXIT_CYCLES = 3;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_role_strap = 1'b1;
  logic i_return_from_hw = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [3:0] i_reg_idx = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic slow = 1'b0;
  pmsc_pkg::pmsc_trig_t cmd = '0;
  pmsc_pkg::pmsc_trig_t i_trig;
  pmsc_pkg::pmsc_rails_t o_rails;
  logic [7:0] o_reg_rdata;
  logic [1:0] o_link_retry_limit;
  logic [2:0] o_state;
  logic o_link_primary, o_link_crc_check_enable, o_link_watchdog_enable;
  logic o_link_watchdog_auto_boot, o_link_logical_secondary, o_external_drive_enable;
  logic o_residual_check_enable, o_first_startup_done, o_analog_supply_monitor_mask;
  logic o_to_fault_recovery;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  pmsc_top #(.EXIT_CYCLES(EXIT_CYCLES)) uut (
    .i_mclk                       (i_mclk),
    .i_rstn                       (i_rstn),
    .i_role_strap                 (i_role_strap),
    .i_return_from_hw             (i_return_from_hw),
    .i_trig                       (i_trig),
    .i_reg_wr                     (i_reg_wr),
    .i_reg_rd                     (i_reg_rd),
    .i_reg_idx                    (i_reg_idx),
    .i_reg_wdata                  (i_reg_wdata),
    .o_reg_rdata                  (o_reg_rdata),
    .o_link_primary               (o_link_primary),
    .o_link_crc_check_enable      (o_link_crc_check_enable),
    .o_link_retry_limit           (o_link_retry_limit),
    .o_link_watchdog_enable       (o_link_watchdog_enable),
    .o_link_watchdog_auto_boot    (o_link_watchdog_auto_boot),
    .o_link_logical_secondary     (o_link_logical_secondary),
    .o_rails                      (o_rails),
    .o_external_drive_enable      (o_external_drive_enable),
    .o_residual_check_enable      (o_residual_check_enable),
    .o_first_startup_done         (o_first_startup_done),
    .o_analog_supply_monitor_mask (o_analog_supply_monitor_mask),
    .o_to_fault_recovery          (o_to_fault_recovery),
    .o_state                      (o_state)
  );
  pmsc_host hst (.i_mclk(i_mclk), .i_cmd(cmd), .i_slow(slow), .o_trig(i_trig));
  // ==========================================================
  // Clock and hang guard; the whole run is about 150 cycles
  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ==========================================================
  // Compare, verdict and transfer tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Apply trigger levels, let sync and update settle, judge state and power
  task automatic step(input logic [6:0] t, input logic s, input logic [2:0] st,
                      input logic [12:0] pw, input logic [12:0] m);
    cmd = t;
    slow = s;
    repeat (8) @(negedge i_mclk);
    cmp({13'h0, o_state}, {13'h0, st});
    cmp({3'h0, {o_rails, o_external_drive_enable} & m}, {3'h0, pw & m});
  endtask : step
  // One register access; read data is judged a cycle after its edge
  task automatic reg_op(input logic w, input logic [3:0] idx, input logic [7:0] d,
                        input logic [7:0] exp, input logic [7:0] m);
    i_reg_wr = w;
    i_reg_rd = !w;
    i_reg_idx = idx;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    @(negedge i_mclk);
    if (!w) cmp({8'h0, o_reg_rdata & m}, {8'h0, exp & m});
  endtask : reg_op
  // Fault exit: dwell in standby, then hand over to recovery
  task automatic fault_exit();
    int n;
    n = 0;
    cmd = 7'h40;
    repeat (20) begin
      @(negedge i_mclk);
      if (o_state === pmsc_pkg::PMSC_STANDBY) n++;
    end
    cmp({13'h0, o_state}, {13'h0, pmsc_pkg::PMSC_RECOVERY});
    cmp({15'h0, n == EXIT_CYCLES}, 16'h1);
    i_return_from_hw = 1'b1;
    step(7'h00, 1'b0, pmsc_pkg::PMSC_STANDBY, 13'h0, 13'h1fff);
    i_return_from_hw = 1'b0;
  endtask : fault_exit
  // ==========================================================
  // Main sequence
  initial begin
    @(negedge i_mclk);
    cmp({1'h0, o_state, o_rails}, 16'h0);
    repeat (2) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_mclk);
    cmp({13'h0, o_state}, {13'h0, pmsc_pkg::PMSC_PREACT});
    cmp({13'h0, o_residual_check_enable, o_first_startup_done,
         o_analog_supply_monitor_mask}, 16'h2);
    cmp({9'h0, o_link_crc_check_enable, o_link_retry_limit, o_link_watchdog_enable,
         o_link_watchdog_auto_boot, o_link_logical_secondary, o_link_primary},
        16'h7f);
    i_role_strap = 1'b0;
    reg_op(1'b0, 4'h0, 8'h00, 8'hff, 8'hff);
    reg_op(1'b0, 4'h1, 8'h00, 8'h01, 8'h01);
    reg_op(1'b1, 4'h0, 8'h5a, 8'h00, 8'h00);
    reg_op(1'b0, 4'h0, 8'h00, 8'h5a, 8'hff);
    reg_op(1'b1, 4'h1, 8'h00, 8'h00, 8'h00);
    reg_op(1'b0, 4'h1, 8'h00, 8'h00, 8'h01);
    reg_op(1'b1, 4'h2, 8'h00, 8'h00, 8'h00);
    reg_op(1'b0, 4'h2, 8'h00, 8'h03, 8'h03);
    reg_op(1'b0, 4'h3, 8'h00, 8'h2e, 8'h2f);
    reg_op(1'b0, 4'h4, 8'h00, 8'h81, 8'h87);
    reg_op(1'b0, 4'hf, 8'h00, 8'h00, 8'hff);
    cmp({15'h0, o_link_primary}, 16'h1);
    step(7'h04, 1'b0, pmsc_pkg::PMSC_PREACT, 13'h0, 13'h1fff);
    step(7'h0c, 1'b1, pmsc_pkg::PMSC_ACTIVE, 13'h1fff, 13'h1fff);
    step(7'h04, 1'b0, pmsc_pkg::PMSC_MCU, 13'h1e00, 13'h1ffe);
    step(7'h08, 1'b0, pmsc_pkg::PMSC_ACTIVE, 13'h1fff, 13'h1fff);
    step(7'h02, 1'b0, pmsc_pkg::PMSC_RETAIN, 13'h000e, 13'h1fff);
    step(7'h08, 1'b0, pmsc_pkg::PMSC_ACTIVE, 13'h1fff, 13'h1fff);
    step(7'h10, 1'b0, pmsc_pkg::PMSC_SOC_ERR, 13'h1e01, 13'h1fff);
    step(7'h08, 1'b0, pmsc_pkg::PMSC_SOC_ERR, 13'h1e01, 13'h1fff);
    step(7'h01, 1'b1, pmsc_pkg::PMSC_MCU, 13'h1e00, 13'h1ffe);
    step(7'h28, 1'b0, pmsc_pkg::PMSC_STANDBY, 13'h0, 13'h1fff);
    step(7'h08, 1'b0, pmsc_pkg::PMSC_ACTIVE, 13'h1fff, 13'h1fff);
    fault_exit();
    i_rstn = 1'b0;
    @(negedge i_mclk);
    cmp({1'h0, o_state, o_rails}, 16'h0);
    print_verdict();
  end
endmodule : tb_top
bind pmsc_top pmsc_monitor #(.EXIT_CYCLES(EXIT_CYCLES)) u_mon (
  .i_mclk                       (i_mclk),
  .i_rstn                       (i_rstn),
  .i_trig                       (i_trig),
  .o_rails                      (o_rails),
  .o_external_drive_enable      (o_external_drive_enable),
  .o_residual_check_enable      (o_residual_check_enable),
  .o_first_startup_done         (o_first_startup_done),
  .o_analog_supply_monitor_mask (o_analog_supply_monitor_mask),
  .o_to_fault_recovery          (o_to_fault_recovery),
  .o_link_crc_check_enable      (o_link_crc_check_enable),
  .o_link_retry_limit           (o_link_retry_limit),
  .o_link_watchdog_enable       (o_link_watchdog_enable),
  .o_link_watchdog_auto_boot    (o_link_watchdog_auto_boot),
  .o_link_logical_secondary     (o_link_logical_secondary),
  .o_state                      (o_state)
);
`default_nettype wire

//--- logic/pmsc_pkg.sv
// Package: constants, states and carriers of the mission state control block
`default_nettype none
package pmsc_pkg;
  // ===========================================================
  // Startup link settings (fixed after startup)
  localparam logic       ROLE_PRIMARY       = 1'h1;
  localparam logic       ROLE_SECONDARY     = 1'h0;
  localparam logic       CRC_ENABLE_RST     = 1'h1;
  localparam logic [1:0] RETRY_LIMIT_RST    = 2'h3;
  localparam logic       WD_AUTO_BOOT_RST   = 1'h1;
  localparam logic       WD_ENABLE_RST      = 1'h1;
  localparam logic       IF_SEL_DEBUG       = 1'h0;
  // ===========================================================
  // Register indices on the I2C-side register port
  localparam logic [3:0] IDX_WD_LONG_WINDOW = 4'h0;
  localparam logic [3:0] IDX_WD_THRESHOLD   = 4'h1;
  localparam logic [3:0] IDX_LINK_CFG_A     = 4'h2;
  localparam logic [3:0] IDX_LINK_CFG_B     = 4'h3;
  localparam logic [3:0] IDX_STATUS         = 4'h4;
  localparam logic [7:0] WD_LONG_WINDOW_RST = 8'hff;
  localparam logic [7:0] WD_THRESHOLD_RST   = 8'h01;
  // Field positions
  localparam int CFGA_CRC_BIT   = 0;
  localparam int CFGA_ROLE_BIT  = 1;
  localparam int CFGB_IFSEL_BIT = 0;
  localparam int CFGB_RETRY_LSB = 1;
  localparam int CFGB_AUTO_BIT  = 3;
  localparam int CFGB_WDEN_BIT  = 5;
  // ===========================================================
  // Rail groups
  localparam int N_MCU_RAILS = 4;
  localparam int N_SOC_RAILS = 8;
  localparam int N_DDR_RAILS = 3;
  localparam logic [7:0] DDR_RAIL_MASK = 8'h07;
  // ===========================================================
  // Mission state machine, Gray along init -> preactive -> active
  typedef enum logic [2:0] {
    PMSC_INIT     = 3'h0,
    PMSC_PREACT   = 3'h1,
    PMSC_ACTIVE   = 3'h3,
    PMSC_MCU      = 3'h2,
    PMSC_SOC_ERR  = 3'h6,
    PMSC_RETAIN   = 3'h7,
    PMSC_STANDBY  = 3'h5,
    PMSC_RECOVERY = 3'h4
  } pmsc_state_t;
  // Request triggers from host, highest priority first in decode
  typedef struct packed {
    logic fault;      // Error forcing exit to recovery; ignored in SoC power error
    logic off_req;
    logic soc_err;
    logic on_req;
    logic mcu_req;
    logic retain_req;
    logic soc_return; // Leave SoC power error for MCU only
  } pmsc_trig_t;
  // Rail enables
  typedef struct packed {
    logic [N_MCU_RAILS-1:0] mcu;
    logic [N_SOC_RAILS-1:0] soc;
  } pmsc_rails_t;
endpackage : pmsc_pkg
`default_nettype wire

//--- logic/pmsc_top.sv
// Top module: link startup settings, watchdog defaults and mission state machine
`default_nettype none
module pmsc_top #(
  parameter int EXIT_CYCLES = 4
) (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rstn,
  // Startup straps, asynchronous pins
  input  wire logic                 i_role_strap,
  input  wire logic                 i_return_from_hw,
  // Host triggers, asynchronous pins
  input  wire pmsc_pkg::pmsc_trig_t i_trig,
  // I2C-side register port, same clock
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [3:0]           i_reg_idx,
  input  wire logic [7:0]           i_reg_wdata,
  output logic [7:0]                o_reg_rdata,
  // Link settings
  output logic                      o_link_primary,
  output logic                      o_link_crc_check_enable,
  output logic [1:0]                o_link_retry_limit,
  output logic                      o_link_watchdog_enable,
  output logic                      o_link_watchdog_auto_boot,
  output logic                      o_link_logical_secondary,
  // Power outputs
  output pmsc_pkg::pmsc_rails_t     o_rails,
  output logic                      o_external_drive_enable,
  output logic                      o_residual_check_enable,
  output logic                      o_first_startup_done,
  output logic                      o_analog_supply_monitor_mask,
  output logic                      o_to_fault_recovery,
  output logic [2:0]                o_state
);

  // The exit counter is 8 bits wide and must see at least one cycle
  if (EXIT_CYCLES < 1 || EXIT_CYCLES > 255) begin : g_bad_exit_cycles
    $error("EXIT_CYCLES out of range");
  end

  // ===========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_q;
  logic       rstn;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'h1};
  end
  assign rstn = rst_q[1];

  // Straps and triggers are pins: two stages before any logic reads them
  localparam int NSYNC = $bits(pmsc_pkg::pmsc_trig_t) + 2;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_role_strap, i_return_from_hw, i_trig};
      sync2_q <= sync1_q;
    end
  end
  pmsc_pkg::pmsc_trig_t trig;
  logic                 strap_s;
  logic                 hw_ret_s;
  assign {strap_s, hw_ret_s, trig} = sync2_q;

  // ===========================================================
  // Configuration registers; link settings freeze after the strap is caught
  logic       role_q, role_d;
  logic [1:0] latched_q, latched_d;
  logic [7:0] wd_long_q, wd_long_d, wd_thr_q, wd_thr_d;
  logic [7:0] cfga, cfgb;

  // Role caught once, on the third edge after reset release, never again;
  // earlier the strap synchroniser still shows its reset zero, not the pin
  always_comb begin
    role_d    = role_q;
    latched_d = (latched_q == 2'h3) ? latched_q : 2'(latched_q + 2'h1);
    if (latched_q == 2'h2) role_d = strap_s;
    wd_long_d = wd_long_q;
    wd_thr_d  = wd_thr_q;
    if (i_reg_wr && i_reg_idx == pmsc_pkg::IDX_WD_LONG_WINDOW) wd_long_d = i_reg_wdata;
    if (i_reg_wr && i_reg_idx == pmsc_pkg::IDX_WD_THRESHOLD) wd_thr_d = i_reg_wdata;
  end

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      role_q    <= pmsc_pkg::ROLE_SECONDARY;
      latched_q <= 2'h0;
      wd_long_q <= pmsc_pkg::WD_LONG_WINDOW_RST;
      wd_thr_q  <= pmsc_pkg::WD_THRESHOLD_RST;
    end else begin
      role_q    <= role_d;
      latched_q <= latched_d;
      wd_long_q <= wd_long_d;
      wd_thr_q  <= wd_thr_d;
    end
  end

  // Fixed link settings; writes to them are ignored by design
  always_comb begin
    cfga = 8'h00;
    cfga[pmsc_pkg::CFGA_CRC_BIT]  = pmsc_pkg::CRC_ENABLE_RST;
    cfga[pmsc_pkg::CFGA_ROLE_BIT] = role_q;
    cfgb = 8'h00;
    cfgb[pmsc_pkg::CFGB_IFSEL_BIT] = pmsc_pkg::IF_SEL_DEBUG;
    cfgb[pmsc_pkg::CFGB_RETRY_LSB +: 2] = pmsc_pkg::RETRY_LIMIT_RST;
    cfgb[pmsc_pkg::CFGB_AUTO_BIT] = pmsc_pkg::WD_AUTO_BOOT_RST;
    cfgb[pmsc_pkg::CFGB_WDEN_BIT] = pmsc_pkg::WD_ENABLE_RST;
  end

  assign o_link_primary            = (role_q == pmsc_pkg::ROLE_PRIMARY);
  assign o_link_crc_check_enable   = cfga[pmsc_pkg::CFGA_CRC_BIT];
  assign o_link_retry_limit        = cfgb[pmsc_pkg::CFGB_RETRY_LSB +: 2];
  assign o_link_watchdog_enable    = cfgb[pmsc_pkg::CFGB_WDEN_BIT];
  assign o_link_watchdog_auto_boot = cfgb[pmsc_pkg::CFGB_AUTO_BIT];
  assign o_link_logical_secondary  =
    (cfgb[pmsc_pkg::CFGB_IFSEL_BIT] == pmsc_pkg::IF_SEL_DEBUG);

  // ===========================================================
  // Mission state machine
  pmsc_pkg::pmsc_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic       fault_q, fault_d;
  logic       boot_q, boot_d;
  logic       rchk_q, rchk_d;
  logic       mask_q, mask_d;

  // One trigger acted on per cycle, tested from highest priority down
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    fault_d = fault_q;
    boot_d  = boot_q;
    rchk_d  = rchk_q;
    mask_d  = mask_q;
    case (st_q)
      pmsc_pkg::PMSC_INIT: begin
        rchk_d = 1'h0;
        boot_d = 1'h1;
        mask_d = 1'h0;
        st_d   = pmsc_pkg::PMSC_PREACT;
      end
      pmsc_pkg::PMSC_PREACT: begin
        // Only fault and power-on act here; other wake requests wait
        if (trig.fault) begin
          st_d = pmsc_pkg::PMSC_STANDBY;
          fault_d = 1'h1;
          cnt_d = 8'h00;
        end else if (trig.on_req) st_d = pmsc_pkg::PMSC_ACTIVE;
      end
      pmsc_pkg::PMSC_ACTIVE, pmsc_pkg::PMSC_MCU, pmsc_pkg::PMSC_RETAIN: begin
        if (trig.fault) begin
          st_d = pmsc_pkg::PMSC_STANDBY;
          fault_d = 1'h1;
          cnt_d = 8'h00;
        end else if (trig.off_req) begin
          st_d = pmsc_pkg::PMSC_STANDBY;
          fault_d = 1'h0;
        end else if (trig.soc_err && st_q == pmsc_pkg::PMSC_ACTIVE) begin
          st_d = pmsc_pkg::PMSC_SOC_ERR;
        end else if (trig.on_req) st_d = pmsc_pkg::PMSC_ACTIVE;
        else if (trig.mcu_req) st_d = pmsc_pkg::PMSC_MCU;
        else if (trig.retain_req && st_q != pmsc_pkg::PMSC_RETAIN) begin
          st_d = pmsc_pkg::PMSC_RETAIN;
        end
      end
      pmsc_pkg::PMSC_SOC_ERR: begin
        if (trig.soc_return) st_d = pmsc_pkg::PMSC_MCU;
      end
      pmsc_pkg::PMSC_STANDBY: begin
        if (fault_q) begin
          // Exit sequence runs to completion before recovery is entered
          cnt_d = 8'(cnt_q + 8'h01);
          if (cnt_q == 8'(EXIT_CYCLES - 1)) st_d = pmsc_pkg::PMSC_RECOVERY;
        end else if (trig.fault) begin
          fault_d = 1'h1;
          cnt_d = 8'h00;
        end else if (trig.off_req) begin
          // Off request holds standby and blocks the lower wake requests
          st_d = pmsc_pkg::PMSC_STANDBY;
        end else if (trig.on_req) st_d = pmsc_pkg::PMSC_ACTIVE;
        else if (trig.mcu_req) st_d = pmsc_pkg::PMSC_MCU;
      end
      pmsc_pkg::PMSC_RECOVERY: begin
        if (hw_ret_s) begin
          st_d = pmsc_pkg::PMSC_STANDBY;
          fault_d = 1'h0;
        end
      end
      default: st_d = pmsc_pkg::PMSC_INIT;
    endcase
  end

  // Reset lands on the initialisation point
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= pmsc_pkg::PMSC_INIT;
      cnt_q   <= 8'h00;
      fault_q <= 1'h0;
      boot_q  <= 1'h0;
      rchk_q  <= 1'h1;
      mask_q  <= 1'h1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      fault_q <= fault_d;
      boot_q  <= boot_d;
      rchk_q  <= rchk_d;
      mask_q  <= mask_d;
    end
  end

  // ===========================================================
  // Rail and drive outputs, registered from the next state
  // so rails switch on the same edge as the state code
  pmsc_pkg::pmsc_rails_t rails_d, rails_q;
  logic                  drv_d, drv_q;
  always_comb begin
    rails_d = '0;
    drv_d   = 1'h0;
    case (st_d)
      pmsc_pkg::PMSC_ACTIVE: begin
        rails_d = '1;
        drv_d   = 1'h1;
      end
      pmsc_pkg::PMSC_MCU, pmsc_pkg::PMSC_SOC_ERR: begin
        rails_d.mcu = '1;
        drv_d       = 1'h1;
      end
      pmsc_pkg::PMSC_RETAIN: begin
        rails_d.soc = pmsc_pkg::DDR_RAIL_MASK;
      end
      default: begin
        rails_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      rails_q <= '0;
      drv_q   <= 1'h0;
    end else begin
      rails_q <= rails_d;
      drv_q   <= drv_d;
    end
  end

  assign o_rails                      = rails_q;
  assign o_external_drive_enable      = drv_q;
  assign o_residual_check_enable      = rchk_q;
  assign o_first_startup_done         = boot_q;
  assign o_analog_supply_monitor_mask = mask_q;
  assign o_to_fault_recovery          = (st_q == pmsc_pkg::PMSC_RECOVERY);
  assign o_state                      = st_q;

  // ===========================================================
  // Register read, registered; unknown index reads zero
  // Only the watchdog pair takes writes; the link settings stay fixed
  logic [7:0] rd_d, rd_q;
  always_comb begin
    rd_d = rd_q;
    if (i_reg_rd) begin
      if (i_reg_idx == pmsc_pkg::IDX_WD_LONG_WINDOW) rd_d = wd_long_q;
      else if (i_reg_idx == pmsc_pkg::IDX_WD_THRESHOLD) rd_d = wd_thr_q;
      else if (i_reg_idx == pmsc_pkg::IDX_LINK_CFG_A) rd_d = cfga;
      else if (i_reg_idx == pmsc_pkg::IDX_LINK_CFG_B) rd_d = cfgb;
      else if (i_reg_idx == pmsc_pkg::IDX_STATUS) rd_d = {boot_q, fault_q, 3'h0, st_q};
      else rd_d = 8'h00;
    end
  end
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) rd_q <= 8'h00;
    else rd_q <= rd_d;
  end
  assign o_reg_rdata = rd_q;

endmodule : pmsc_top
`default_nettype wire
